// [src/um_baud.sv]
// baud rate generator: one oversample tick every divisor+1 clocks
// assumes run is synchronous to pclk
`timescale 1ns/10ps
module um_baud #(
  parameter int unsigned W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  logic [W-1:0] cnt;

  if (W < 2)
  begin : g_bad
    $error("um_baud divisor too narrow");
  end

  // counter stops and clears while the transceiver is halted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt >= divisor)
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + W'(1);
      tick <= 1'b0;
    end
  end
endmodule

// [src/um_pkg.sv]
// shared constants and types of the serial mode-control block
// assumes an apb master with 32-bit data and byte addresses on paddr
package um_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFF_MODE = 8'h00;
  localparam logic [AW-1:0] OFF_STAT = 8'h04;
  localparam logic [AW-1:0] OFF_MASK = 8'h08;
  localparam logic [AW-1:0] OFF_BAUD = 8'h0c;
  localparam logic [AW-1:0] OFF_TXD  = 8'h10;
  localparam logic [AW-1:0] OFF_RXD  = 8'h14;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  // status bit positions
  localparam int unsigned STAT_W  = 7;
  localparam int unsigned EV_TX   = 0;
  localparam int unsigned EV_RX   = 1;
  localparam int unsigned EV_PAR  = 2;
  localparam int unsigned EV_FRM  = 3;
  localparam int unsigned EV_OVR  = 4;
  localparam int unsigned EV_WAKE = 5;
  localparam int unsigned EV_AB   = 6;
  localparam int unsigned RO_TXP  = 8;
  localparam int unsigned RO_RXF  = 9;
  localparam int unsigned RO_BUSY = 10;
  // oversampling, infrared pulse width, auto-rate
  localparam logic [4:0] OS_STD    = 5'h10;
  localparam logic [4:0] OS_FAST   = 5'h04;
  localparam logic [4:0] IR_PULSE  = 5'h03;
  localparam logic [2:0] AB_EDGES  = 3'h5;
  localparam int unsigned AB_SH_STD  = 7;
  localparam int unsigned AB_SH_FAST = 5;
  localparam int unsigned AB_CW      = 24;
  // character formats and pin usage codes
  localparam logic [1:0] FMT_9N = 2'h3;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] PINS_RTS     = 2'h1;
  localparam logic [1:0] PINS_RTS_CTS = 2'h2;
  localparam logic [1:0] PINS_BCLK    = 2'h3;

  typedef struct packed {
    logic       serial_module_on;
    logic       rsv14;
    logic       halt_in_idle;
    logic       infrared_codec_on;
    logic       rts_pin_behaviour;
    logic       rsv10;
    logic [1:0] pin_usage_select;
    logic       wake;
    logic       internal_loop_on;
    logic       auto_rate_measure;
    logic       rx_idle_polarity;
    logic       fast_oversample_select;
    logic [1:0] char_format_select;
    logic       stop_count_select;
  } um_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } um_state_t;
endpackage

// [src/um_sync.sv]
// three-stage synchroniser for pins, one lane per bit
// assumes the inputs are asynchronous to pclk
`timescale 1ns/10ps
module um_sync #(
  parameter int unsigned N    = 1,
  parameter logic [N-1:0] INIT = '1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] d,
  output logic      [N-1:0] q
);
  if (N < 1)
  begin : g_bad
    $error("um_sync needs at least one lane");
  end

  // a change is taken once stages two and three agree
  for (genvar i = 0; i < N; i++)
  begin : g_lane
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1   <= INIT[i];
        s2   <= INIT[i];
        s3   <= INIT[i];
        q[i] <= INIT[i];
      end
      else
      begin
        s1 <= d[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
          q[i] <= s3;
      end
    end
  end
endmodule

// [src/um_uart_mode.sv]
// serial transceiver with its mode register, reached over apb
// assumes apb master on pclk; pins are asynchronous; cpu_idle is on pclk
`timescale 1ns/10ps
// Notes on behaviour
// - module off: pins released to port latches; on: pins as usage selects
// - halt bit plus cpu idle stops the transceiver; clear keeps it running
// - infrared bit inserts pulse encoder on transmit and decoder on receive
// - infrared coding works only with sixteen-times oversampling
// - rts behaviour bit: one is simplex, zero is flow control
// - pin usage field picks tx/rx, plus rts, plus rts and cts, or bclk
// - wake bit: falling rx edge interrupts, following rising edge clears bit
// - loopback bit returns transmitted data to the receiver internally
// - auto-rate measures next 0x55 character, then hardware clears the bit
// - receive polarity one means idle low, zero means idle high
// - fast bit gives four ticks per bit, otherwise sixteen
// - format field: 9 bits none, 8 odd, 8 even, 8 none
// - stop select gives two stop bits when set, one when clear
module um_uart_mode import um_pkg::*; #(
  parameter int unsigned DIV_W      = 16,
  parameter logic [15:0] BAUD_RESET = 16'h0010
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          cpu_idle,
  input  wire logic          serial_rx_pin,
  input  wire logic          clear_to_send_pin_n,
  output logic               serial_tx_pin,
  output logic               serial_tx_oe,
  output logic               request_to_send_pin_n,
  output logic               request_to_send_oe,
  output logic               baud_clock_out,
  output logic               baud_clock_oe,
  output logic               irq
);
  um_mode_t          mode;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [STAT_W-1:0] ev;
  logic [DIV_W-1:0]  divisor;
  logic [8:0]        tx_buf;
  logic [8:0]        rx_data;
  logic              tx_pend;
  logic              rx_full;
  logic              rx_s;
  logic              cts_s;
  logic              tick;
  logic              run;
  logic              ir_act;
  logic              par_on;
  logic              par_odd;
  logic [3:0]        nbits;
  logic [4:0]        os;
  logic [4:0]        os_last;
  logic              wr_en;
  logic              rd_en;
  logic              tx_take;
  logic              rx_pol;
  logic              rx_line;
  logic [4:0]        ir_cnt;
  logic              ab_run;
  logic [2:0]        ab_edges;
  logic [AB_CW-1:0]  ab_cnt;
  logic              ab_done;
  logic              line_prev;
  logic              pol_prev;
  logic              wake_seen;
  logic              wake_fall;
  logic              wake_rise;
  um_state_t         tx_st;
  logic [4:0]        tx_sub;
  logic [3:0]        tx_idx;
  logic [8:0]        tx_sh;
  logic              tx_bit;
  logic              tx_par;
  logic              tx_stop_left;
  logic              tx_done;
  um_state_t         rx_st;
  logic [4:0]        rx_sub;
  logic [3:0]        rx_idx;
  logic [8:0]        rx_sh;
  logic [8:0]        next_rx_sh;
  logic              rx_par;
  logic              rx_perr;
  logic              rx_ferr;
  logic              rx_stop_left;
  logic              rx_done;
  logic              rx_done_perr;
  logic              rx_done_ferr;

  if (DIV_W < 8 || DIV_W > 16)
  begin : g_bad
    $error("um_uart_mode divisor width must be 8 to 16");
  end

  um_sync #(.N(2), .INIT(2'h3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({serial_rx_pin, clear_to_send_pin_n}),
    .q       ({rx_s, cts_s})
  );

  um_baud #(.W(DIV_W)) u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .divisor (divisor),
    .tick    (tick)
  );

  // mode decode
  assign run     = mode.serial_module_on & ~(mode.halt_in_idle & cpu_idle);
  assign ir_act  = mode.infrared_codec_on & ~mode.fast_oversample_select;
  assign os      = mode.fast_oversample_select ? OS_FAST : OS_STD;
  assign os_last = os - 5'h01;
  assign nbits   = (mode.char_format_select == FMT_9N) ? 4'h9 : 4'h8;
  assign par_on  = (mode.char_format_select == FMT_8O) | (mode.char_format_select == FMT_8E);
  assign par_odd = (mode.char_format_select == FMT_8O);
  assign wr_en   = psel & penable & pready & pwrite;
  assign rd_en   = psel & penable & pready & ~pwrite;
  assign tx_take = tick & (tx_st == ST_IDLE) & tx_pend &
                   ((mode.pin_usage_select != PINS_RTS_CTS) | ~cts_s);
  // receive source: polarity, infrared decoder, loopback
  assign rx_pol  = rx_s ^ mode.rx_idle_polarity;
  assign rx_line = mode.internal_loop_on ? tx_bit : (ir_act ? (ir_cnt == 5'h00) : rx_pol);
  assign next_rx_sh = {rx_line, rx_sh[8:1]};
  assign wake_fall  = mode.serial_module_on & mode.wake & pol_prev & ~rx_pol;
  assign wake_rise  = wake_seen & ~pol_prev & rx_pol;
  assign ev = {ab_done, wake_fall, rx_done & rx_full, rx_done_ferr, rx_done_perr, rx_done, tx_done};

  // apb slave: registered answer, one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel & ~penable)
      begin
        unique case (paddr)
          OFF_MODE: prdata <= {16'h0000, mode};
          OFF_STAT: prdata <= 32'({tx_st != ST_IDLE, rx_full, tx_pend, 1'b0, status});
          OFF_MASK: prdata <= 32'(mask);
          OFF_BAUD: prdata <= 32'(divisor);
          OFF_TXD:  prdata <= 32'(tx_buf);
          OFF_RXD:  prdata <= 32'(rx_data);
          default:  pslverr <= 1'b1;
        endcase
      end
    end
  end

  // mode register, hardware clears wake and auto-rate bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= um_mode_t'(MODE_RST);
    else if (wr_en && paddr == OFF_MODE)
      mode <= um_mode_t'(pwdata[15:0] & MODE_WMASK);
    else
    begin
      if (wake_rise)
        mode.wake <= 1'b0;
      if (ab_done)
        mode.auto_rate_measure <= 1'b0;
    end
  end

  // divisor: software or the auto-rate result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divisor <= DIV_W'(BAUD_RESET);
    else if (ab_done)
      divisor <= DIV_W'((ab_cnt >> (mode.fast_oversample_select ? AB_SH_FAST : AB_SH_STD)) - 1);
    else if (wr_en && paddr == OFF_BAUD)
      divisor <= pwdata[DIV_W-1:0];
  end

  // sticky status, write one to clear, event wins; mask and interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == OFF_STAT)
        status <= (status & ~pwdata[STAT_W-1:0]) | ev;
      else
        status <= status | ev;
      if (wr_en && paddr == OFF_MASK)
        mask <= pwdata[STAT_W-1:0];
      irq <= |(status & mask);
    end
  end

  // transmit holding word and receive full flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf  <= '0;
      tx_pend <= 1'b0;
      rx_full <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == OFF_TXD)
      begin
        tx_buf  <= pwdata[8:0];
        tx_pend <= 1'b1;
      end
      else if (tx_take || !mode.serial_module_on)
        tx_pend <= 1'b0;
      if (rx_done)
        rx_full <= 1'b1;
      else if (rd_en && paddr == OFF_RXD)
        rx_full <= 1'b0;
    end
  end

  // transmit framer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st <= ST_IDLE;
      tx_sub <= '0;
      tx_idx <= '0;
      tx_sh <= '0;
      tx_bit <= 1'b1;
      tx_par <= 1'b0;
      tx_stop_left <= 1'b0;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (!mode.serial_module_on)
      begin
        tx_st <= ST_IDLE;
        tx_bit <= 1'b1;
      end
      else if (tx_take)
      begin
        tx_st <= ST_START;
        tx_bit <= 1'b0;
        tx_sub <= '0;
        tx_sh <= tx_buf;
        tx_par <= 1'b0;
      end
      else if (tick && tx_st != ST_IDLE)
      begin
        tx_sub <= tx_sub + 5'h01;
        if (tx_sub == os_last)
        begin
          tx_sub <= '0;
          unique case (tx_st)
            ST_START:
            begin
              tx_st <= ST_DATA;
              tx_bit <= tx_sh[0];
              tx_idx <= '0;
            end
            ST_DATA:
            begin
              tx_par <= tx_par ^ tx_bit;
              tx_sh <= tx_sh >> 1;
              tx_idx <= tx_idx + 4'h1;
              tx_bit <= tx_sh[1];
              if (tx_idx == nbits - 4'h1)
              begin
                tx_st <= par_on ? ST_PAR : ST_STOP;
                tx_bit <= par_on ? (tx_par ^ tx_bit ^ par_odd) : 1'b1;
                tx_stop_left <= mode.stop_count_select;
              end
            end
            ST_PAR:
            begin
              tx_st <= ST_STOP;
              tx_bit <= 1'b1;
            end
            default:
            begin
              if (tx_stop_left)
                tx_stop_left <= 1'b0;
              else
              begin
                tx_st <= ST_IDLE;
                tx_done <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // infrared decoder: a pulse holds the line low for one bit time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ir_cnt <= '0;
    else if (!rx_pol)
      ir_cnt <= os_last;
    else if (tick && ir_cnt != 5'h00)
      ir_cnt <= ir_cnt - 5'h01;
  end

  // receive deframer, idle while auto-rate runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st <= ST_IDLE;
      rx_sub <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_stop_left <= 1'b0;
      rx_data <= '0;
      rx_done <= 1'b0;
      rx_done_perr <= 1'b0;
      rx_done_ferr <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      rx_done_perr <= 1'b0;
      rx_done_ferr <= 1'b0;
      if (!mode.serial_module_on || mode.auto_rate_measure)
        rx_st <= ST_IDLE;
      else if (tick)
      begin
        rx_sub <= rx_sub + 5'h01;
        unique case (rx_st)
          ST_IDLE:
          begin
            rx_sub <= '0;
            rx_par <= 1'b0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
            rx_idx <= '0;
            if (!rx_line)
              rx_st <= ST_START;
          end
          ST_START:
            if (rx_sub == (os >> 1) - 5'h01)
            begin
              rx_sub <= '0;
              rx_st <= rx_line ? ST_IDLE : ST_DATA;
            end
          ST_DATA:
            if (rx_sub == os_last)
            begin
              rx_sub <= '0;
              rx_sh <= next_rx_sh;
              rx_par <= rx_par ^ rx_line;
              rx_idx <= rx_idx + 4'h1;
              rx_stop_left <= mode.stop_count_select;
              if (rx_idx == nbits - 4'h1)
                rx_st <= par_on ? ST_PAR : ST_STOP;
            end
          ST_PAR:
            if (rx_sub == os_last)
            begin
              rx_sub <= '0;
              rx_perr <= rx_par ^ rx_line ^ par_odd;
              rx_st <= ST_STOP;
            end
          default:
            if (rx_sub == os_last)
            begin
              rx_sub <= '0;
              if (rx_stop_left)
              begin
                rx_stop_left <= 1'b0;
                rx_ferr <= rx_ferr | ~rx_line;
              end
              else
              begin
                rx_st <= ST_IDLE;
                rx_data <= (nbits == 4'h9) ? rx_sh : {1'b0, rx_sh[8:1]};
                rx_done <= 1'b1;
                rx_done_perr <= rx_perr;
                rx_done_ferr <= rx_ferr | ~rx_line;
              end
            end
        endcase
      end
    end
  end

  // auto-rate: five falling edges of 0x55 span eight bit times
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_prev <= 1'b1;
      ab_run <= 1'b0;
      ab_edges <= '0;
      ab_cnt <= '0;
      ab_done <= 1'b0;
    end
    else
    begin
      line_prev <= rx_line;
      ab_done <= 1'b0;
      if (!mode.serial_module_on || !mode.auto_rate_measure || ab_done)
      begin
        ab_run <= 1'b0;
        ab_edges <= '0;
        ab_cnt <= '0;
      end
      else
      begin
        if (ab_run)
          ab_cnt <= ab_cnt + AB_CW'(1);
        if (line_prev && !rx_line)
        begin
          ab_run <= 1'b1;
          ab_edges <= ab_edges + 3'h1;
          if (ab_edges == AB_EDGES - 3'h1)
            ab_done <= 1'b1;
        end
      end
    end
  end

  // wake detector on the pin itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pol_prev <= 1'b1;
      wake_seen <= 1'b0;
    end
    else
    begin
      pol_prev <= rx_pol;
      if (wake_fall)
        wake_seen <= 1'b1;
      else if (wake_rise || !mode.wake)
        wake_seen <= 1'b0;
    end
  end

  // pin drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_tx_pin <= 1'b1;
      serial_tx_oe <= 1'b0;
      request_to_send_pin_n <= 1'b1;
      request_to_send_oe <= 1'b0;
      baud_clock_out <= 1'b0;
      baud_clock_oe <= 1'b0;
    end
    else
    begin
      serial_tx_oe <= mode.serial_module_on;
      if (mode.internal_loop_on)
        serial_tx_pin <= ~ir_act;
      else if (ir_act)
        serial_tx_pin <= ~tx_bit & (tx_sub < IR_PULSE);
      else
        serial_tx_pin <= tx_bit;
      request_to_send_oe <= mode.serial_module_on & ((mode.pin_usage_select == PINS_RTS) |
                            (mode.pin_usage_select == PINS_RTS_CTS));
      if (mode.rts_pin_behaviour)
        request_to_send_pin_n <= (tx_st == ST_IDLE);
      else
        request_to_send_pin_n <= rx_full;
      baud_clock_oe <= mode.serial_module_on & (mode.pin_usage_select == PINS_BCLK);
      if (tick)
        baud_clock_out <= ~baud_clock_out;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    tx_take && !mode.internal_loop_on;
  endsequence

  a_off_release: assert property (!mode.serial_module_on |=> !serial_tx_oe && !baud_clock_oe)
    else $error("pins driven while module off");
  a_halt_freeze: assert property (mode.halt_in_idle && cpu_idle |=> !tick)
    else $error("baud tick while halted in idle");
  a_ir_pulse_end: assert property (ir_act && !mode.internal_loop_on && tx_sub >= IR_PULSE |=> !serial_tx_pin)
    else $error("infrared pulse too long");
  a_fast_no_ir: assert property (mode.fast_oversample_select && !mode.internal_loop_on |=> serial_tx_pin == $past(tx_bit))
    else $error("infrared coding in fast mode");
  a_rts_simplex: assert property (mode.rts_pin_behaviour && tx_st != ST_IDLE |=> !request_to_send_pin_n)
    else $error("rts not asserted while sending");
  a_rts_usage: assert property (mode.pin_usage_select == PINS_BCLK |=> !request_to_send_oe)
    else $error("rts driven in baud clock usage");
  a_wake_clear: assert property (wake_rise && !wr_en |=> !mode.wake)
    else $error("wake bit not cleared on rising edge");
  a_loop_idle: assert property (mode.internal_loop_on && !ir_act |=> serial_tx_pin)
    else $error("pin not idle in loopback");
  a_auto_rate_measure_clear: assert property (ab_done && !wr_en |=> !mode.auto_rate_measure)
    else $error("auto-rate bit not cleared");
  a_rx_invert: assert property (!mode.internal_loop_on && !ir_act |-> rx_line == (rx_s ^ mode.rx_idle_polarity))
    else $error("receive polarity wrong");
  a_sub_range: assert property (tx_sub <= os_last || $changed(os))
    else $error("sub-bit count past oversample");
  a_par_only: assert property (tx_st == ST_PAR |-> par_on)
    else $error("parity bit without parity format");
  a_two_stops: assert property (tx_st == ST_STOP && tx_stop_left && tick && tx_sub == os_last |=> tx_st == ST_STOP)
    else $error("second stop bit skipped");
  a_start_low: assert property (s_take |=> tx_st == ST_START ##1 !serial_tx_pin || ir_act)
    else $error("start bit not low");
endmodule

// [testbench/test_uart_mode_control.sv]
// self-checking bench of the serial mode-control block
// assumes um_remote on the pins and apb driven from this module
`timescale 1ns/10ps
module test_uart_mode_control;
  import um_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, idle;
  logic          txoe, rtsoe, rtsn, bcoe;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, r;
  logic          rxp, txp;
  logic [32:0]   q[$];
  logic [10:0]   got, e;
  logic [8:0]    w;
  int            mismatches, n_tests, seed;
  um_uart_mode um_uart_mode_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(idle), .serial_rx_pin(rxp), .clear_to_send_pin_n(1'b0),
    .serial_tx_pin(txp), .serial_tx_oe(txoe), .request_to_send_pin_n(rtsn), .request_to_send_oe(rtsoe),
    .baud_clock_out(), .baud_clock_oe(bcoe), .irq(irq));
  um_remote um_remote_inst (.pclk(pclk), .line_in(txp), .line_out(rxp));
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    mismatches++;
    final_report();
  end
  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] x);
    n_tests++;
    if (s !== x)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following request never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  // read results compared against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
      check("read", {pslverr, prdata}, q.pop_front());
  initial
  begin
    seed = 15;
    {psel, penable, pwrite, paddr, pwdata, idle} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_MODE, {1'b0, 16'h0, MODE_RST});
    rd(8'h18, 33'h100000000);
    r = 32'($random(seed)) & 32'h7fff;
    apb(1'b1, OFF_MODE, r);
    rd(OFF_MODE, {17'h0, r[15:0] & MODE_WMASK});
    $display("registers done");
    apb(1'b1, OFF_BAUD, 32'h1);
    apb(1'b1, OFF_MASK, 32'h2);
    // every format in both oversampling modes
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, OFF_MODE, 32'h8000 | (i << 1) | (i & 1));
      w = 9'($random(seed));
      e = (i[1:0] == 2'h0) ? {2'b11, w[7:0], 1'b0} : (i[1:0] == 2'h3) ? {1'b1, w, 1'b0}
        : {1'b1, i[1] ^ (^w[7:0]), w[7:0], 1'b0};
      fork
        apb(1'b1, OFF_TXD, {23'h0, w});
        um_remote_inst.recv(got, (i[1:0] == 2'h0) ? 10 : 11, i[2] ? 8 : 32);
      join
      // let a second stop bit finish before the mode changes
      repeat (32) @(posedge pclk);
      check("tx frame", {22'h0, got}, {22'h0, e});
    end
    $display("transmit done");
    // halted in idle: the queued word waits until idle ends
    idle <= 1'b1;
    apb(1'b1, OFF_MODE, 32'ha000);
    apb(1'b1, OFF_TXD, 32'ha5);
    repeat (200) @(posedge pclk);
    check("halt line", {32'h0, txp}, 33'h1);
    fork
      idle <= 1'b0;
      um_remote_inst.recv(got, 10, 32);
    join
    check("halt frame", {22'h0, got}, {22'h0, 2'b11, 8'ha5, 1'b0});
    $display("halt done");
    apb(1'b1, OFF_MODE, 32'h8000);
    apb(1'b1, OFF_STAT, 32'h7f);
    w = 9'($random(seed));
    um_remote_inst.send(w[7:0], 32);
    for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge pclk);
    check("irq", {32'h0, irq}, 33'h1);
    rd(OFF_RXD, {25'h0, w[7:0]});
    apb(1'b1, OFF_STAT, 32'h2);
    @(posedge pclk);
    check("irq", {32'h0, irq}, 33'h0);
    $display("receive done");
    // pin ownership follows enable, usage code and rts behaviour
    apb(1'b1, OFF_MODE, 32'h8a00);
    @(posedge pclk);
    check("pins", {29'h0, txoe, rtsoe, rtsn, bcoe}, {29'h0, 4'he});
    apb(1'b1, OFF_MODE, 32'h8300);
    @(posedge pclk);
    check("pins", {29'h0, txoe, rtsoe, rtsn, bcoe}, {29'h0, 4'h9});
    apb(1'b1, OFF_MODE, 32'h0);
    @(posedge pclk);
    check("pins", {29'h0, txoe, rtsoe, rtsn, bcoe}, {29'h0, 4'h0});
    $display("pins done");
    // auto-rate: 0x55 at 64 clocks a bit spans 512 clocks, divisor 512/128-1
    apb(1'b1, OFF_MODE, 32'h8020);
    um_remote_inst.send(8'h55, 64);
    rd(OFF_BAUD, 33'h3);
    rd(OFF_MODE, 33'h8000);
    $display("auto-rate done");
    final_report();
  end
endmodule

// [testbench/um_remote.sv]
// remote serial transceiver on the line: sends frames and decodes them
// assumes the caller gives the bit time in pclk cycles
`timescale 1ns/10ps
module um_remote (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  // line idles high between frames
  initial line_out = 1'b1;
  // low start, eight data bits lsb first, one stop at idle level
  task automatic send(input logic [7:0] d, input int bc);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (bc) @(posedge pclk);
    end
  endtask
  // catches a frame from its falling start edge, sampling mid-bit
  task automatic recv(output logic [10:0] d, input int n, input int bc);
    d = 11'h7ff;
    @(negedge line_in);
    repeat (bc / 2) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      d[i] = line_in;
      repeat (bc) @(posedge pclk);
    end
  endtask
endmodule
